// >>> verilog/stc_counter_unit.sv
// Sixteen-bit timer/counter core with APB register access
// Notes on behaviour
// - Sixteen-bit counter counting up or down, with count, direction, clear.
// - Each timer tick clears, increments or decrements per active mode.
// - Clock source zero gives no tick; counter holds.
// - Clock source picks prescaled internal clock or external pin edge.
// - Software reads and writes the counter at any time.
// - Software counter write beats a same-cycle clear or count.
// - High-byte accesses go to the shared eight-bit temporary register.
// - Reading the low byte copies the high byte into temporary.
// - Writing the low byte loads all sixteen bits at once.
// - Bottom indication whenever the counter is zero.
// - All ones is the counter maximum.
// - Top comes from compare A, capture register or a fixed value.
// - Compare A as PWM top is double buffered, no PWM on A.
// - Both compares checked on every timer tick except the first tick after a counter write; matches set their flags.
// - Four-bit waveform mode split over both control registers.
// - Overflow flag set at the mode's overflow point.
// - Four interrupt sources: overflow, match A, match B, capture.
// - Four flags in one flag register, masked by one mask register.
// - Both control registers read and write directly.
// - Capture on chosen edge of pin or comparator, optional filter.
// - Capture flag set in the same cycle the value is captured.
// - Match flag set on the tick after counter equals compare.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module stc_counter_unit #(
  parameter int NOISE_DEPTH = stc_pkg::NOISE_DEPTH_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event inputs
  input wire logic ext_count_pin,
  input wire logic capture_pin,
  input wire logic comparator_in,
  // Status toward the waveform and interrupt logic
  output logic [15:0] count_value,
  output logic timer_tick,
  output logic count_at_top,
  output logic count_at_bottom,
  output logic match_a_pulse,
  output logic match_b_pulse,
  output logic irq_overflow,
  output logic irq_match_a,
  output logic irq_match_b,
  output logic irq_capture
);
  generate
    if (NOISE_DEPTH < 2 || NOISE_DEPTH > 8) begin : g_bad_depth
      $error("NOISE_DEPTH must lie between 2 and 8");
    end
  endgenerate

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic logic [9:0] psc_mask(input logic [2:0] cs);
    case (cs)
      stc_pkg::CS_DIV8: psc_mask = stc_pkg::PSC_M8;
      stc_pkg::CS_DIV64: psc_mask = stc_pkg::PSC_M64;
      stc_pkg::CS_DIV256: psc_mask = stc_pkg::PSC_M256;
      default: psc_mask = stc_pkg::PSC_M1024;
    endcase
  endfunction

  function automatic logic is_dual(input logic [3:0] m);
    is_dual = (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hb);
  endfunction

  function automatic logic is_ctc(input logic [3:0] m);
    is_ctc = (m == 4'h4) || (m == 4'hc);
  endfunction

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !(m == 4'h0 || m == 4'hd || is_ctc(m));
  endfunction

  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'h0) && (a <= stc_pkg::OFS_MASK);
  endfunction

  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [7:0] temp_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic up_reg;
  logic up_next;
  logic [15:0] bufa_reg;
  logic [15:0] bufb_reg;
  logic [15:0] cmpa_reg;
  logic [15:0] cmpb_reg;
  logic [15:0] cap_reg;
  logic [7:0] flag_reg;
  logic [7:0] mask_reg;
  logic [9:0] psc_reg;
  logic ext_prev_reg;
  logic block_reg;
  logic ack_reg;
  logic [31:0] prdata_reg;
  logic [NOISE_DEPTH-1:0] nc_reg;
  logic filt_reg;
  logic lvl_prev_reg;
  logic [3:0] wgm;
  logic [2:0] cs;
  logic tick;
  logic dual;
  logic [15:0] top_val;
  logic at_top;
  logic at_zero;
  logic wr_en;
  logic rd_en;
  logic cnt_wr;
  logic cnt_rd;
  logic set_ovf;
  logic set_a;
  logic set_b;
  logic cap_lvl;
  logic cap_evt;
  logic buf_load;
  logic [7:0] rd_mux;

  assign wgm = {ctrl_b_reg[stc_pkg::CB_WGM_HI +: 2],
                ctrl_a_reg[stc_pkg::CA_WGM_LO +: 2]};
  assign cs = ctrl_b_reg[stc_pkg::CB_CS +: 3];
  assign dual = is_dual(wgm);

  // APB handshake: one wait state so read data comes from a flop
  assign wr_en = psel && penable && ack_reg && pwrite;
  assign rd_en = psel && penable && !ack_reg && !pwrite;
  assign pready = ack_reg;
  assign pslverr = ack_reg && !addr_mapped(paddr);
  assign prdata = prdata_reg;
  assign cnt_wr = wr_en && (paddr == stc_pkg::OFS_CNT_LO);
  assign cnt_rd = rd_en && (paddr == stc_pkg::OFS_CNT_LO);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= psel && penable && !ack_reg;
    end
  end

  // Prescaler and clock source selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_reg <= 10'h000;
      ext_prev_reg <= 1'b0;
    end else begin
      psc_reg <= 10'(psc_reg + 10'h001);
      ext_prev_reg <= ext_count_pin;
    end
  end

  always_comb begin
    case (cs)
      stc_pkg::CS_STOP: tick = 1'b0;
      stc_pkg::CS_DIV1: tick = 1'b1;
      stc_pkg::CS_EXT_FALL: tick = ext_prev_reg && !ext_count_pin;
      stc_pkg::CS_EXT_RISE: tick = !ext_prev_reg && ext_count_pin;
      default: tick = (psc_reg & psc_mask(cs)) == psc_mask(cs);
    endcase
  end

  // Top of count by mode
  always_comb begin
    case (wgm)
      4'h1, 4'h5: top_val = stc_pkg::TOP_8BIT;
      4'h2, 4'h6: top_val = stc_pkg::TOP_9BIT;
      4'h3, 4'h7: top_val = stc_pkg::TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: top_val = cmpa_reg;
      4'h8, 4'ha, 4'hc, 4'he: top_val = cap_reg;
      default: top_val = stc_pkg::CNT_MAX;
    endcase
  end
  assign at_top = count_reg == top_val;
  assign at_zero = count_reg == stc_pkg::CNT_BOTTOM;

  // Counter next value: software write first, then the tick
  always_comb begin
    count_next = count_reg;
    up_next = dual ? up_reg : 1'b1;
    if (cnt_wr) begin
      count_next = {temp_reg, pwdata[7:0]};
    end else if (tick) begin
      if (dual) begin
        if (up_reg && at_top) begin
          count_next = count_reg - 16'h0001;
          up_next = 1'b0;
        end else if (!up_reg && at_zero) begin
          count_next = count_reg + 16'h0001;
          up_next = 1'b1;
        end else if (up_reg) begin
          count_next = count_reg + 16'h0001;
        end else begin
          count_next = count_reg - 16'h0001;
        end
      end else if (at_top) begin
        count_next = stc_pkg::CNT_BOTTOM;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= stc_pkg::RST_WORD;
      up_reg <= 1'b1;
    end else begin
      count_reg <= count_next;
      up_reg <= up_next;
    end
  end

  // A counter write suppresses the compare match on the next tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_reg <= 1'b0;
    end else if (cnt_wr) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_reg <= stc_pkg::RST_BYTE;
      ctrl_b_reg <= stc_pkg::RST_BYTE;
    end else if (wr_en && paddr == stc_pkg::OFS_CTRL_A) begin
      ctrl_a_reg <= pwdata[7:0];
    end else if (wr_en && paddr == stc_pkg::OFS_CTRL_B) begin
      ctrl_b_reg <= pwdata[7:0];
    end
  end

  // Shared temporary byte for sixteen-bit access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_reg <= stc_pkg::RST_BYTE;
    end else if (wr_en && (paddr == stc_pkg::OFS_CNT_HI ||
                           paddr == stc_pkg::OFS_CMPA_HI ||
                           paddr == stc_pkg::OFS_CMPB_HI ||
                           paddr == stc_pkg::OFS_CAP_HI)) begin
      temp_reg <= pwdata[7:0];
    end else if (cnt_rd) begin
      temp_reg <= count_reg[15:8];
    end else if (rd_en && paddr == stc_pkg::OFS_CMPA_LO) begin
      temp_reg <= bufa_reg[15:8];
    end else if (rd_en && paddr == stc_pkg::OFS_CMPB_LO) begin
      temp_reg <= bufb_reg[15:8];
    end else if (rd_en && paddr == stc_pkg::OFS_CAP_LO) begin
      temp_reg <= cap_reg[15:8];
    end
  end

  // Compare buffers and active compare values
  assign buf_load = !is_pwm(wgm) ||
    (tick && ((wgm == 4'h8 || wgm == 4'h9) ? at_zero : at_top));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bufa_reg <= stc_pkg::RST_WORD;
      bufb_reg <= stc_pkg::RST_WORD;
    end else if (wr_en && paddr == stc_pkg::OFS_CMPA_LO) begin
      bufa_reg <= {temp_reg, pwdata[7:0]};
    end else if (wr_en && paddr == stc_pkg::OFS_CMPB_LO) begin
      bufb_reg <= {temp_reg, pwdata[7:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_reg <= stc_pkg::RST_WORD;
      cmpb_reg <= stc_pkg::RST_WORD;
    end else if (buf_load) begin
      cmpa_reg <= bufa_reg;
      cmpb_reg <= bufb_reg;
    end
  end

  // Capture input: optional majority-free noise filter, edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nc_reg <= '0;
      filt_reg <= 1'b0;
      lvl_prev_reg <= 1'b0;
    end else begin
      nc_reg <= {nc_reg[NOISE_DEPTH-2:0],
                 ctrl_b_reg[stc_pkg::CB_CAP_SRC] ? comparator_in
                                                 : capture_pin};
      if (nc_reg == {NOISE_DEPTH{1'b1}}) begin
        filt_reg <= 1'b1;
      end else if (nc_reg == {NOISE_DEPTH{1'b0}}) begin
        filt_reg <= 1'b0;
      end
      lvl_prev_reg <= cap_lvl;
    end
  end
  assign cap_lvl = ctrl_b_reg[stc_pkg::CB_NOISE] ? filt_reg : nc_reg[0];
  assign cap_evt = !cap_is_top(wgm) && (ctrl_b_reg[stc_pkg::CB_EDGE]
    ? (cap_lvl && !lvl_prev_reg) : (!cap_lvl && lvl_prev_reg));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_reg <= stc_pkg::RST_WORD;
    end else if (cap_evt) begin
      cap_reg <= count_reg;
    end else if (cap_is_top(wgm) && wr_en &&
                 paddr == stc_pkg::OFS_CAP_LO) begin
      cap_reg <= {temp_reg, pwdata[7:0]};
    end
  end

  // Flag sources; a set in the clearing cycle wins
  assign set_ovf = tick && !cnt_wr && (dual ? (!up_reg && at_zero)
    : is_ctc(wgm) ? (count_reg == stc_pkg::CNT_MAX) : at_top);
  assign set_a = tick && !block_reg && (count_reg == cmpa_reg);
  assign set_b = tick && !block_reg && (count_reg == cmpb_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= stc_pkg::RST_BYTE;
    end else begin
      if (wr_en && paddr == stc_pkg::OFS_FLAG) begin
        flag_reg <= flag_reg & ~pwdata[7:0];
      end
      if (set_ovf) flag_reg[stc_pkg::FLAG_OVF] <= 1'b1;
      if (set_a) flag_reg[stc_pkg::FLAG_A] <= 1'b1;
      if (set_b) flag_reg[stc_pkg::FLAG_B] <= 1'b1;
      if (cap_evt) flag_reg[stc_pkg::FLAG_CAP] <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= stc_pkg::RST_BYTE;
    end else if (wr_en && paddr == stc_pkg::OFS_MASK) begin
      mask_reg <= pwdata[7:0];
    end
  end

  // Read multiplexer; high bytes always read the temporary register
  always_comb begin
    case (paddr)
      stc_pkg::OFS_CTRL_A: rd_mux = ctrl_a_reg;
      stc_pkg::OFS_CTRL_B: rd_mux = ctrl_b_reg;
      stc_pkg::OFS_CNT_LO: rd_mux = count_reg[7:0];
      stc_pkg::OFS_CMPA_LO: rd_mux = bufa_reg[7:0];
      stc_pkg::OFS_CMPB_LO: rd_mux = bufb_reg[7:0];
      stc_pkg::OFS_CAP_LO: rd_mux = cap_reg[7:0];
      stc_pkg::OFS_CNT_HI, stc_pkg::OFS_CMPA_HI,
      stc_pkg::OFS_CMPB_HI, stc_pkg::OFS_CAP_HI: rd_mux = temp_reg;
      stc_pkg::OFS_FLAG: rd_mux = flag_reg & 8'he8;
      stc_pkg::OFS_MASK: rd_mux = mask_reg & 8'he8;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_en) begin
      prdata_reg <= {24'h000000, rd_mux};
    end
  end

  // Registered status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= stc_pkg::RST_WORD;
      timer_tick <= 1'b0;
      count_at_top <= 1'b0;
      count_at_bottom <= 1'b1;
      match_a_pulse <= 1'b0;
      match_b_pulse <= 1'b0;
    end else begin
      count_value <= count_next;
      timer_tick <= tick;
      count_at_top <= count_next == top_val;
      count_at_bottom <= count_next == stc_pkg::CNT_BOTTOM;
      match_a_pulse <= set_a;
      match_b_pulse <= set_b;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_overflow <= 1'b0;
      irq_match_a <= 1'b0;
      irq_match_b <= 1'b0;
      irq_capture <= 1'b0;
    end else begin
      irq_overflow <= flag_reg[stc_pkg::FLAG_OVF] &&
                      mask_reg[stc_pkg::MASK_OVF];
      irq_match_a <= flag_reg[stc_pkg::FLAG_A] && mask_reg[stc_pkg::MASK_A];
      irq_match_b <= flag_reg[stc_pkg::FLAG_B] && mask_reg[stc_pkg::MASK_B];
      irq_capture <= flag_reg[stc_pkg::FLAG_CAP] &&
                     mask_reg[stc_pkg::MASK_CAP];
    end
  end

  // Checks
  sequence s_turn_at_top;
    dual && up_reg && at_top && tick && !cnt_wr;
  endsequence

  sequence s_went_down;
    !up_reg ##0 (count_reg == $past(count_reg) - 16'h0001);
  endsequence

  a_stop_holds: assert property (
    (cs == stc_pkg::CS_STOP && !cnt_wr) |=> $stable(count_reg))
    else $error("counter moved with no clock source");
  a_write_wins: assert property (
    cnt_wr |=> count_reg == {$past(temp_reg), $past(pwdata[7:0])})
    else $error("counter write lost to a count");
  a_low_read_temp: assert property (
    cnt_rd |=> temp_reg == $past(count_reg[15:8]))
    else $error("low byte read did not latch high byte");
  a_high_write_temp: assert property (
    (wr_en && paddr == stc_pkg::OFS_CNT_HI && cs == stc_pkg::CS_STOP)
    |=> $stable(count_reg) && temp_reg == $past(pwdata[7:0]))
    else $error("high byte write reached the counter");
  a_bottom_level: assert property (
    count_at_bottom == (count_value == stc_pkg::CNT_BOTTOM))
    else $error("bottom indication wrong");
  a_dual_turn: assert property (
    s_turn_at_top |=> s_went_down)
    else $error("dual slope did not turn at top");
  a_match_flag: assert property (
    (tick && !block_reg && count_reg == cmpa_reg)
    |=> flag_reg[stc_pkg::FLAG_A] && match_a_pulse)
    else $error("match A flag not set");
  a_capture_flag: assert property (
    cap_evt |=> cap_reg == $past(count_reg) && flag_reg[stc_pkg::FLAG_CAP])
    else $error("capture value and flag not together");
  a_ovf_normal: assert property (
    (wgm == 4'h0 && tick && !cnt_wr && count_reg == stc_pkg::CNT_MAX)
    |=> count_reg == stc_pkg::CNT_BOTTOM && flag_reg[stc_pkg::FLAG_OVF])
    else $error("overflow at max missed");
  a_ctrl_write: assert property (
    (wr_en && paddr == stc_pkg::OFS_CTRL_A) |=>
    ctrl_a_reg == $past(pwdata[7:0]))
    else $error("control A write lost");
  a_irq_gate: assert property (
    (flag_reg[stc_pkg::FLAG_OVF] && !mask_reg[stc_pkg::MASK_OVF])
    |=> !irq_overflow)
    else $error("masked overflow still raised request");
endmodule

// >>> verilog/stc_pkg.sv
// Constants shared by the sixteen-bit counter unit
package stc_pkg;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CNT_LO = 8'h08;
  localparam logic [7:0] OFS_CNT_HI = 8'h0c;
  localparam logic [7:0] OFS_CMPA_LO = 8'h10;
  localparam logic [7:0] OFS_CMPA_HI = 8'h14;
  localparam logic [7:0] OFS_CMPB_LO = 8'h18;
  localparam logic [7:0] OFS_CMPB_HI = 8'h1c;
  localparam logic [7:0] OFS_CAP_LO = 8'h20;
  localparam logic [7:0] OFS_CAP_HI = 8'h24;
  localparam logic [7:0] OFS_FLAG = 8'h28;
  localparam logic [7:0] OFS_MASK = 8'h2c;
  // Field positions
  localparam int CA_WGM_LO = 0;
  localparam int CB_CS = 0;
  localparam int CB_WGM_HI = 3;
  localparam int CB_CAP_SRC = 5;
  localparam int CB_EDGE = 6;
  localparam int CB_NOISE = 7;
  localparam int FLAG_OVF = 7;
  localparam int FLAG_B = 6;
  localparam int FLAG_A = 5;
  localparam int FLAG_CAP = 3;
  localparam int MASK_OVF = 7;
  localparam int MASK_A = 6;
  localparam int MASK_B = 5;
  localparam int MASK_CAP = 3;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Clock source codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] PSC_M8 = 10'h007;
  localparam logic [9:0] PSC_M64 = 10'h03f;
  localparam logic [9:0] PSC_M256 = 10'h0ff;
  localparam logic [9:0] PSC_M1024 = 10'h3ff;
  // Count limits
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam int NOISE_DEPTH_DEF = 4;
endpackage

// >>> tb/stc_cpu_model.sv
// Processor-side model: an APB master with bounded waits
`timescale 1ns/1ps
module stc_cpu_model (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e,
      output logic to);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    to = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines stop showing the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// >>> tb/sixteen_bit_counter_unit_test.sv
// Self-checking bench for the sixteen-bit counter unit
`timescale 1ns/1ps
module sixteen_bit_counter_unit_test;
  localparam logic [7:0] CA = stc_pkg::OFS_CTRL_A;
  localparam logic [7:0] CB = stc_pkg::OFS_CTRL_B;
  localparam logic [7:0] CNT = stc_pkg::OFS_CNT_LO;
  localparam logic [7:0] FLG = stc_pkg::OFS_FLAG;
  localparam logic [7:0] MSK = stc_pkg::OFS_MASK;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic ext_count_pin = 1'b0;
  logic capture_pin = 1'b0;
  logic comparator_in = 1'b0;
  logic [15:0] count_value, v;
  logic timer_tick, count_at_top, count_at_bottom, match_a_pulse;
  logic match_b_pulse, irq_overflow, irq_match_a, irq_match_b, irq_capture;
  logic [31:0] seed = 32'hca47368e;
  int err_count = 0;
  int num_checks = 0;
  int model_cnt;
  int n;
  int n_tick = 0;
  int n_ma = 0;
  int n_mb = 0;

  always #12.5 pclk = ~pclk;

  // Count the one-cycle status pulses while they stand
  always @(posedge pclk) begin
    if (timer_tick === 1'b1) n_tick <= n_tick + 1;
    if (match_a_pulse === 1'b1) n_ma <= n_ma + 1;
    if (match_b_pulse === 1'b1) n_mb <= n_mb + 1;
  end

  stc_counter_unit stc_counter_unit_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
    .capture_pin(capture_pin), .comparator_in(comparator_in),
    .count_value(count_value), .timer_tick(timer_tick),
    .count_at_top(count_at_top), .count_at_bottom(count_at_bottom),
    .match_a_pulse(match_a_pulse), .match_b_pulse(match_b_pulse),
    .irq_overflow(irq_overflow), .irq_match_a(irq_match_a),
    .irq_match_b(irq_match_b), .irq_capture(irq_capture));

  stc_cpu_model stc_cpu_model_inst (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_reg(string s, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic chk_pin(string s, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    logic e;
    logic to;
    stc_cpu_model_inst.xfer(w, a, {24'h0, d}, rd, e, to);
    if (to) begin
      err_count++;
      report_and_stop();
    end
    chk_pin("pslverr", {15'h0, a > MSK}, {15'h0, e});
  endtask

  // Sixteen-bit registers go high byte first on writes, low first on reads
  task automatic set16(logic [7:0] a, logic [15:0] d);
    bus(1'b1, a + 8'h04, d[15:8]);
    bus(1'b1, a, d[7:0]);
  endtask

  task automatic get16(logic [7:0] a);
    logic [7:0] lo;
    bus(1'b0, a, 8'h00);
    lo = rd[7:0];
    bus(1'b0, a + 8'h04, 8'h00);
    v = {rd[7:0], lo};
  endtask

  task automatic flags(logic [7:0] e);
    bus(1'b0, FLG, 8'h00);
    chk_reg("flags", {24'h0, e}, rd);
  endtask

  task automatic pulses(int k);
    repeat (k) begin
      @(posedge pclk);
      ext_count_pin <= 1'b1;
      repeat (2) @(posedge pclk);
      ext_count_pin <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk_pin("bottom", 16'h1, {15'h0, count_at_bottom});
    for (int i = 0; i < 12; i++) begin
      bus(1'b0, 8'(i * 4), 8'h00);
      chk_reg("reset value", 32'h0, rd);
    end
    bus(1'b0, 8'h30, 8'h00);
    chk_reg("unmapped", 32'h0, rd);
    r = rnd();
    bus(1'b1, CA, r[7:0]);
    bus(1'b1, CB, r[15:8] & 8'hf8);
    bus(1'b0, CA, 8'h00);
    chk_reg("control a", {24'h0, r[7:0]}, rd);
    bus(1'b0, CB, 8'h00);
    chk_reg("control b", {24'h0, r[15:8] & 8'hf8}, rd);
    bus(1'b1, CA, 8'h00);
    bus(1'b1, CB, 8'h00);
    model_cnt = int'(r[31:16] & 16'h7fff);
    set16(CNT, model_cnt[15:0]);
    repeat (20) @(posedge pclk);
    get16(CNT);
    chk_reg("held count", model_cnt, {16'h0, v});
    bus(1'b1, CNT + 8'h04, 8'hff);
    bus(1'b0, CNT + 8'h04, 8'h00);
    chk_reg("temp", 32'hff, rd);
    chk_pin("count", model_cnt[15:0], count_value);
    bus(1'b1, CB, {5'h0, stc_pkg::CS_EXT_RISE});
    pulses(5);
    bus(1'b1, CB, {5'h0, stc_pkg::CS_EXT_FALL});
    pulses(3);
    model_cnt += 8;
    get16(CNT);
    chk_reg("ext count", model_cnt, {16'h0, v});
    chk_pin("count", model_cnt[15:0], count_value);
    chk_reg("ticks", 32'h8, n_tick);
    // Compare B one step below A, so the flags rise one tick apart
    bus(1'b1, CB, 8'h00);
    bus(1'b1, MSK, 8'h68);
    set16(stc_pkg::OFS_CMPA_LO, v + 16'h2);
    set16(stc_pkg::OFS_CMPB_LO, v + 16'h1);
    set16(CNT, v);
    bus(1'b1, FLG, 8'he8);
    bus(1'b1, CB, {5'h0, stc_pkg::CS_EXT_RISE});
    pulses(2);
    flags(8'h40);
    pulses(1);
    flags(8'h60);
    chk_pin("irq a b", 16'h3, {14'h0, irq_match_a, irq_match_b});
    chk_reg("match a pulses", 32'h1, n_ma);
    chk_reg("match b pulses", 32'h1, n_mb);
    set16(CNT, 16'hfffe);
    bus(1'b1, FLG, 8'he8);
    pulses(2);
    flags(8'h80);
    chk_pin("masked ovf", 16'h0, {15'h0, irq_overflow});
    chk_pin("wrap", 16'h0, count_value);
    chk_pin("bottom", 16'h1, {15'h0, count_at_bottom});
    bus(1'b1, MSK, 8'he8);
    bus(1'b0, MSK, 8'h00);
    chk_reg("mask", 32'he8, rd);
    chk_pin("ovf irq", 16'h1, {15'h0, irq_overflow});
    bus(1'b1, FLG, 8'he8);
    flags(8'h00);
    // Dual slope with top 0x00ff: turn at top, overflow at bottom
    bus(1'b1, CA, 8'h01);
    set16(CNT, 16'h00fe);
    pulses(1);
    chk_pin("top", 16'h1, {15'h0, count_at_top});
    pulses(2);
    chk_pin("down count", 16'h00fd, count_value);
    set16(CNT, 16'h0001);
    bus(1'b1, FLG, 8'he8);
    pulses(2);
    bus(1'b0, FLG, 8'h00);
    chk_reg("dual ovf", 32'h80, rd & 32'h80);
    chk_pin("up again", 16'h0001, count_value);
    // Second pass takes the comparator with the noise filter on
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, CB, 8'h40 | 8'(s * 160));
      model_cnt = int'(rnd() & 32'hffff);
      set16(CNT, model_cnt[15:0]);
      bus(1'b1, FLG, 8'he8);
      // The request output trails the flag by one cycle
      repeat (2) @(posedge pclk);
      chk_pin("irq cleared", 16'h0, {15'h0, irq_capture});
      if (s == 0) begin
        capture_pin <= 1'b1;
      end else begin
        comparator_in <= 1'b1;
      end
      n = 0;
      while (irq_capture !== 1'b1 && n < 30) begin
        @(posedge pclk);
        n++;
      end
      if (n == 30) begin
        err_count++;
        report_and_stop();
      end
      get16(stc_pkg::OFS_CAP_LO);
      chk_reg("capture", model_cnt, {16'h0, v});
      flags(8'h08);
      capture_pin <= 1'b0;
      comparator_in <= 1'b0;
    end
    report_and_stop();
  end
endmodule
